// [hw/afbic_top.sv]
// Autofocus result base and IIR set 0 tap register bank, Wishbone slave
//
// Our own choices: the address map and the Wishbone slave port.
`include "afbic_map.svh"
`default_nettype none

module afbic_top #(
    parameter int ADDR_W = 8
) (
    // Clock, reset and enable
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    // Frame timing from the engine, same clock
    input wire logic frame_start,
    input wire logic frame_end,
    // Configuration to the engine
    output logic [31:0] af_result_buffer_base,
    output logic frame_running,
    output var afbic_pkg::afbic_tap_t iir_tap_zero,
    output var afbic_pkg::afbic_tap_t iir_tap_one,
    output var afbic_pkg::afbic_tap_t iir_tap_two,
    output var afbic_pkg::afbic_tap_t iir_tap_three,
    output var afbic_pkg::afbic_tap_t iir_tap_four,
    output var afbic_pkg::afbic_tap_t iir_tap_five,
    output var afbic_pkg::afbic_tap_t iir_tap_six,
    output var afbic_pkg::afbic_tap_t iir_tap_seven,
    output var afbic_pkg::afbic_tap_t iir_tap_eight,
    output var afbic_pkg::afbic_tap_t iir_tap_nine
);

    localparam int PAIRS = `AFBIC_TAP_PAIRS;
    localparam int CNT_W = `AFBIC_ST_CNT_W;

    // ---------------------------------------------------------------
    // Bus request decode
    // ---------------------------------------------------------------
    logic req;
    logic wr_fire;
    logic [7:0] adr_word;
    logic sel_base;
    logic sel_act;
    logic sel_status;
    logic [PAIRS-1:0] sel_pair;
    logic mapped;
    logic ack_r;
    logic [31:0] dat_r;
    logic [31:0] rd_nxt;

    // Low two address bits select bytes, which sel already covers
    assign adr_word = {wb_adr_i[7:2], 2'b00};
    assign req = wb_cyc_i && wb_stb_i;

    // Writes land on the edge at which the master sees ack
    assign wr_fire = req && wb_we_i && ack_r;

    assign sel_base = (adr_word == `AFBIC_OFS_BUF_BASE);
    assign sel_act = (adr_word == `AFBIC_OFS_ACT_BASE);
    assign sel_status = (adr_word == `AFBIC_OFS_STATUS);

    always_comb begin
        sel_pair[0] = (adr_word == `AFBIC_OFS_TAPS_1_0);
        sel_pair[1] = (adr_word == `AFBIC_OFS_TAPS_3_2);
        sel_pair[2] = (adr_word == `AFBIC_OFS_TAPS_5_4);
        sel_pair[3] = (adr_word == `AFBIC_OFS_TAPS_7_6);
        sel_pair[4] = (adr_word == `AFBIC_OFS_TAPS_9_8);
    end

    assign mapped = sel_base || sel_act || sel_status || (|sel_pair);

    // ---------------------------------------------------------------
    // Result buffer base
    // ---------------------------------------------------------------
    logic [31:0] shadow_q;
    logic [31:0] active_q;
    logic pending_q;
    logic frame_load;

    // Each frame start picks up the latest software value
    assign frame_load = frame_start;

    afbic_base_shadow u_base (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ce(ce),
        .wr_en(wr_fire && sel_base),
        .wr_sel(wb_sel_i),
        .wr_data(wb_dat_i),
        .frame_load(frame_load),
        .shadow_q(shadow_q),
        .active_q(active_q),
        .pending_q(pending_q)
    );

    assign af_result_buffer_base = active_q;

    // ---------------------------------------------------------------
    // IIR set 0 tap pairs
    // ---------------------------------------------------------------
    afbic_pkg::afbic_tap_t tap_q [0:2*PAIRS-1];
    logic [31:0] pair_rd [0:PAIRS-1];

    genvar g;
    generate
        for (g = 0; g < PAIRS; g = g + 1) begin : g_pair
            afbic_tap_pair u_pair (
                .clk_sys(clk_sys),
                .rstn(rstn),
                .ce(ce),
                .wr_en(wr_fire && sel_pair[g]),
                .wr_sel(wb_sel_i),
                .wr_data(wb_dat_i),
                .tap_even(tap_q[2*g]),
                .tap_odd(tap_q[2*g+1]),
                .rd_word(pair_rd[g])
            );
        end
    endgenerate

    // Ascending pairs: register n holds taps 2n and 2n+1
    assign iir_tap_zero = tap_q[0];
    assign iir_tap_one = tap_q[1];
    assign iir_tap_two = tap_q[2];
    assign iir_tap_three = tap_q[3];
    assign iir_tap_four = tap_q[4];
    assign iir_tap_five = tap_q[5];
    assign iir_tap_six = tap_q[6];
    assign iir_tap_seven = tap_q[7];
    assign iir_tap_eight = tap_q[8];
    assign iir_tap_nine = tap_q[9];

    // ---------------------------------------------------------------
    // Frame tracking
    // ---------------------------------------------------------------
    afbic_pkg::afbic_frame_e frame_r;
    afbic_pkg::afbic_frame_e frame_nxt;

    // A start while running is a back-to-back frame, not an error
    always_comb begin
        frame_nxt = frame_r;
        unique case (frame_r)
            afbic_pkg::AFBIC_FRM_IDLE: begin
                if (frame_start) begin
                    frame_nxt = afbic_pkg::AFBIC_FRM_RUN;
                end
            end
            afbic_pkg::AFBIC_FRM_RUN: begin
                if (frame_start) begin
                    frame_nxt = afbic_pkg::AFBIC_FRM_RUN;
                end else if (frame_end) begin
                    frame_nxt = afbic_pkg::AFBIC_FRM_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            frame_r <= afbic_pkg::AFBIC_FRM_IDLE;
        end else if (ce) begin
            frame_r <= frame_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            frame_running <= 1'b0;
        end else if (ce) begin
            frame_running <= (frame_nxt == afbic_pkg::AFBIC_FRM_RUN);
        end
    end

    // Frame counter wraps; software only uses it to see progress
    logic [CNT_W-1:0] frame_cnt_r;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            frame_cnt_r <= '0;
        end else if (ce && frame_start) begin
            frame_cnt_r <= frame_cnt_r + CNT_W'(1);
        end
    end

    // ---------------------------------------------------------------
    // Late write flag
    // ---------------------------------------------------------------
    // Set when the base is written while a frame runs, telling software
    // that the value waits for the next frame. Cleared by writing one;
    // a new late write in the same cycle keeps it set.
    logic late_r;
    logic late_set;
    logic late_clr;

    assign late_set = wr_fire && sel_base &&
        (frame_r == afbic_pkg::AFBIC_FRM_RUN);
    assign late_clr = wr_fire && sel_status && wb_sel_i[0] &&
        wb_dat_i[`AFBIC_ST_LATE_BIT];

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            late_r <= 1'b0;
        end else if (ce) begin
            if (late_set) begin
                late_r <= 1'b1;
            end else if (late_clr) begin
                late_r <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Read mux
    // ---------------------------------------------------------------
    logic [31:0] status_word;

    always_comb begin
        status_word = `AFBIC_RST_WORD;
        status_word[`AFBIC_ST_RUN_BIT] =
            (frame_r == afbic_pkg::AFBIC_FRM_RUN);
        status_word[`AFBIC_ST_PEND_BIT] = pending_q;
        status_word[`AFBIC_ST_LATE_BIT] = late_r;
        status_word[`AFBIC_ST_CNT_LSB +: CNT_W] = frame_cnt_r;
    end

    always_comb begin
        rd_nxt = `AFBIC_RST_WORD;
        if (sel_base) begin
            rd_nxt = shadow_q;
        end else if (sel_act) begin
            rd_nxt = active_q;
        end else if (sel_status) begin
            rd_nxt = status_word;
        end else begin
            for (int k = 0; k < PAIRS; k++) begin
                if (sel_pair[k]) begin
                    rd_nxt = pair_rd[k];
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Wishbone answer
    // ---------------------------------------------------------------
    // One wait state: ack rises the cycle after the request and falls
    // the cycle after that; unmapped words answer with zero and drop
    // writes, so a stray access never hangs the bus.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ack_r <= 1'b0;
        end else if (ce) begin
            ack_r <= req && !ack_r;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            dat_r <= `AFBIC_RST_WORD;
        end else if (ce && req && !ack_r) begin
            dat_r <= (mapped && !wb_we_i) ? rd_nxt : `AFBIC_RST_WORD;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

endmodule : afbic_top

`default_nettype wire

// [hw/afbic_map.svh]
// Register offsets, field positions and reset values of the tap bank
`ifndef AFBIC_MAP_SVH
`define AFBIC_MAP_SVH

// ---------------------------------------------------------------
// Byte offsets on the register bus
// ---------------------------------------------------------------
`define AFBIC_OFS_BUF_BASE 8'h00
`define AFBIC_OFS_TAPS_1_0 8'h04
`define AFBIC_OFS_TAPS_3_2 8'h08
`define AFBIC_OFS_TAPS_5_4 8'h0c
`define AFBIC_OFS_TAPS_7_6 8'h10
`define AFBIC_OFS_TAPS_9_8 8'h14
`define AFBIC_OFS_ACT_BASE 8'h18
`define AFBIC_OFS_STATUS 8'h1c

// ---------------------------------------------------------------
// Field layout
// ---------------------------------------------------------------
`define AFBIC_ALIGN_BITS 6
`define AFBIC_TAP_W 12
`define AFBIC_TAP_FRAC 6
`define AFBIC_TAP_LO_LSB 0
`define AFBIC_TAP_HI_LSB 16
`define AFBIC_TAP_PAIRS 5
`define AFBIC_ST_RUN_BIT 0
`define AFBIC_ST_PEND_BIT 1
`define AFBIC_ST_LATE_BIT 2
`define AFBIC_ST_CNT_LSB 8
`define AFBIC_ST_CNT_W 8

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define AFBIC_RST_BASE 32'h0000_0000
`define AFBIC_RST_TAP 12'h000
`define AFBIC_RST_WORD 32'h0000_0000

`endif

// [hw/afbic_pkg.sv]
// Types shared by the tap bank modules
`default_nettype none

package afbic_pkg;

    // Signed tap, six fractional bits
    typedef logic signed [11:0] afbic_tap_t;

    // Frame tracking, Gray along idle -> run
    typedef enum logic [0:0] {
        AFBIC_FRM_IDLE = 1'b0,
        AFBIC_FRM_RUN = 1'b1
    } afbic_frame_e;

endpackage : afbic_pkg

`default_nettype wire

// [hw/afbic_tap_pair.sv]
// One register holding an even tap and the following odd tap
`include "afbic_map.svh"
`default_nettype none

module afbic_tap_pair (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    // Write port
    input wire logic wr_en,
    input wire logic [3:0] wr_sel,
    input wire logic [31:0] wr_data,
    // Stored taps
    output var afbic_pkg::afbic_tap_t tap_even,
    output var afbic_pkg::afbic_tap_t tap_odd,
    output logic [31:0] rd_word
);

    // ---------------------------------------------------------------
    // Byte-lane writes; upper nibbles of each half do not exist
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            tap_even <= `AFBIC_RST_TAP;
            tap_odd <= `AFBIC_RST_TAP;
        end else if (ce && wr_en) begin
            if (wr_sel[0]) begin
                tap_even[7:0] <= wr_data[7:0];
            end
            if (wr_sel[1]) begin
                tap_even[11:8] <= wr_data[11:8];
            end
            if (wr_sel[2]) begin
                tap_odd[7:0] <= wr_data[23:16];
            end
            if (wr_sel[3]) begin
                tap_odd[11:8] <= wr_data[27:24];
            end
        end
    end

    // Reserved bits 31..28 and 15..12 read as zero
    assign rd_word = {4'h0, tap_odd, 4'h0, tap_even};

endmodule : afbic_tap_pair

`default_nettype wire

// [hw/afbic_base_shadow.sv]
// Result buffer base: software copy and per-frame active copy
`include "afbic_map.svh"
`default_nettype none

module afbic_base_shadow (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    // Write port
    input wire logic wr_en,
    input wire logic [3:0] wr_sel,
    input wire logic [31:0] wr_data,
    // Frame boundary
    input wire logic frame_load,
    // State
    output logic [31:0] shadow_q,
    output logic [31:0] active_q,
    output logic pending_q
);

    integer i;

    // ---------------------------------------------------------------
    // Software copy, any time, full 32 bits kept for readback
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            shadow_q <= `AFBIC_RST_BASE;
        end else if (ce && wr_en) begin
            for (i = 0; i < 4; i = i + 1) begin
                if (wr_sel[i]) begin
                    shadow_q[i*8 +: 8] <= wr_data[i*8 +: 8];
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Active copy, loaded only at a frame start
    // ---------------------------------------------------------------
    // A write in the same cycle as the load lands next frame, so the
    // engine never sees a half-updated word.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            active_q <= `AFBIC_RST_BASE;
        end else if (ce && frame_load) begin
            active_q <= {shadow_q[31:`AFBIC_ALIGN_BITS],
                `AFBIC_ALIGN_BITS'(0)};
        end
    end

    // Pending update; a new write wins over the load clearing it
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pending_q <= 1'b0;
        end else if (ce) begin
            if (wr_en) begin
                pending_q <= 1'b1;
            end else if (frame_load) begin
                pending_q <= 1'b0;
            end
        end
    end

endmodule : afbic_base_shadow

`default_nettype wire

// [hw/afbic_top_tail.sv]
// Intentionally empty compile unit
`default_nettype none
`default_nettype wire

// [sim/afbic_top_monitor.sv]
// Port checker for the tap bank
`include "afbic_map.svh"
`default_nettype none

module afbic_top_chk #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    // Frame side
    input wire logic frame_start,
    input wire logic frame_end,
    input wire logic [31:0] af_result_buffer_base,
    input wire logic frame_running,
    input wire afbic_pkg::afbic_tap_t iir_tap_zero,
    input wire afbic_pkg::afbic_tap_t iir_tap_one
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    a_ack_after_req: assert property (
        ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ack_one_pulse: assert property (
        ce && wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_base_aligned: assert property (
        af_result_buffer_base[5:0] == 6'h00)
        else $error("base not aligned");
    a_base_held_midframe: assert property (
        ce && !frame_start |=> $stable(af_result_buffer_base))
        else $error("base moved without frame start");
    a_start_runs: assert property (
        ce && frame_start |=> frame_running)
        else $error("not running after start");
    a_end_idles: assert property (
        ce && frame_end && !frame_start |=> !frame_running)
        else $error("running after end");
    a_tap_pair_write: assert property (
        ce && wb_ack_o && wb_we_i && wb_sel_i == 4'hf
        && wb_adr_i == `AFBIC_OFS_TAPS_1_0
        |=> iir_tap_zero == $past(wb_dat_i[11:0])
        && iir_tap_one == $past(wb_dat_i[27:16]))
        else $error("tap pair write lost");
    a_tap_gaps_zero: assert property (
        wb_ack_o && !wb_we_i && wb_adr_i >= 8'h04 && wb_adr_i < 8'h18
        |-> wb_dat_o[15:12] == 4'h0 && wb_dat_o[31:28] == 4'h0)
        else $error("reserved tap bits not zero");
    a_unmapped_zero: assert property (
        wb_ack_o && !wb_we_i && wb_adr_i >= 8'h20 |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_ce_freeze: assert property (
        !ce |=> $stable(af_result_buffer_base) && $stable(frame_running)
        && $stable(wb_ack_o))
        else $error("state moved while enable low");
endmodule : afbic_top_chk

bind afbic_top afbic_top_chk #(.ADDR_W(ADDR_W)) afbic_top_chk_inst (
    .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .frame_start(frame_start),
    .frame_end(frame_end), .af_result_buffer_base(af_result_buffer_base),
    .frame_running(frame_running), .iir_tap_zero(iir_tap_zero),
    .iir_tap_one(iir_tap_one));

`default_nettype wire

// [sim/afbic_top_tb_top.sv]
// Self-checking bench of the tap bank
`include "afbic_map.svh"
`default_nettype none

module afbic_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic frame_start = 1'b0;
    logic frame_end = 1'b0;
    logic ce = 1'b1;
    logic wb_ack_o;
    logic [31:0] wb_dat_o;
    logic [31:0] base;
    logic frame_running;
    afbic_pkg::afbic_tap_t tap_w [10];
    int miscompares = 0;
    int checks = 0;

    always #50 clk_sys = ~clk_sys;

    afbic_top afbic_top_inst (
        .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o), .frame_start(frame_start),
        .frame_end(frame_end), .af_result_buffer_base(base),
        .frame_running(frame_running), .iir_tap_zero(tap_w[0]),
        .iir_tap_one(tap_w[1]), .iir_tap_two(tap_w[2]),
        .iir_tap_three(tap_w[3]), .iir_tap_four(tap_w[4]),
        .iir_tap_five(tap_w[5]), .iir_tap_six(tap_w[6]),
        .iir_tap_seven(tap_w[7]), .iir_tap_eight(tap_w[8]),
        .iir_tap_nine(tap_w[9]));

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Ack and read data are taken on the rising edge, as the slave sees it
    task automatic bus(input logic we, input logic [7:0] adr,
        input logic [31:0] dat, input logic [3:0] sel,
        output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= sel;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            miscompares++;
            complete_run();
        end else begin
            rd = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            wb_we_i <= 1'b0;
            #1;
        end
    endtask : bus

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat,
        input logic [3:0] sel);
        logic [31:0] unused_rd;
        bus(1'b1, adr, dat, sel, unused_rd);
    endtask : wr

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] got;
        bus(1'b0, adr, 32'h0, 4'hf, got);
        check(got, exp);
    endtask : rd_chk

    task automatic pulse(input logic st);
        @(posedge clk_sys);
        frame_start <= st;
        frame_end <= !st;
        @(posedge clk_sys);
        frame_start <= 1'b0;
        frame_end <= 1'b0;
        #1;
    endtask : pulse

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset_vals();
        for (int a = 0; a < 6; a++) begin
            rd_chk(8'(4 * a), 32'h0);
        end
        check(base, 32'h0);
        for (int i = 0; i < 10; i++) begin
            check({20'h0, tap_w[i]}, 32'h0);
        end
    endtask : t_reset_vals

    task automatic t_taps();
        logic [11:0] ev;
        logic [11:0] od;
        for (int k = 0; k < 5; k++) begin
            ev = 12'h800 + 12'(k);
            od = 12'h7ff - 12'(k);
            wr(8'(4 + 4 * k), {4'hf, od, 4'hf, ev}, 4'hf);
            rd_chk(8'(4 + 4 * k), {4'h0, od, 4'h0, ev});
            check({20'h0, tap_w[2 * k]}, {20'h0, ev});
            check({20'h0, tap_w[2 * k + 1]}, {20'h0, od});
        end
        wr(`AFBIC_OFS_TAPS_1_0, 32'h0055_0000, 4'h4);
        check({20'h0, tap_w[1]}, 32'h0000_0755);
    endtask : t_taps

    task automatic t_base_frame();
        wr(`AFBIC_OFS_BUF_BASE, 32'h1234_5678, 4'hf);
        rd_chk(`AFBIC_OFS_BUF_BASE, 32'h1234_5678);
        pulse(1'b1);
        check(base, 32'h1234_5640);
        wr(`AFBIC_OFS_BUF_BASE, 32'hdead_beef, 4'hf);
        rd_chk(`AFBIC_OFS_BUF_BASE, 32'hdead_beef);
        check(base, 32'h1234_5640);
        pulse(1'b0);
        check(base, 32'h1234_5640);
        pulse(1'b1);
        check(base, 32'hdead_bec0);
    endtask : t_base_frame

    // Status: run b0, pending b1, late b2 (write one to clear), count 15:8
    task automatic t_status();
        rd_chk(`AFBIC_OFS_STATUS, 32'h0000_0205);
        rd_chk(`AFBIC_OFS_ACT_BASE, 32'hdead_bec0);
        wr(`AFBIC_OFS_ACT_BASE, 32'hffff_ffff, 4'hf);
        wr(`AFBIC_OFS_STATUS, 32'h0000_0004, 4'h1);
        rd_chk(`AFBIC_OFS_ACT_BASE, 32'hdead_bec0);
        rd_chk(`AFBIC_OFS_STATUS, 32'h0000_0201);
        wr(`AFBIC_OFS_BUF_BASE, 32'h0000_0040, 4'hf);
        rd_chk(`AFBIC_OFS_STATUS, 32'h0000_0207);
        pulse(1'b0);
        check({31'h0, frame_running}, 32'h0);
        check(base, 32'hdead_bec0);
        pulse(1'b1);
        check({31'h0, frame_running}, 32'h1);
        rd_chk(`AFBIC_OFS_STATUS, 32'h0000_0305);
        check(base, 32'h0000_0040);
    endtask : t_status

    // A frame start while the enable is low must change nothing
    task automatic t_ce_freeze();
        wr(`AFBIC_OFS_BUF_BASE, 32'h0000_2000, 4'hf);
        @(posedge clk_sys);
        ce <= 1'b0;
        pulse(1'b1);
        check(base, 32'h0000_0040);
        check({31'h0, frame_running}, 32'h1);
        @(posedge clk_sys);
        ce <= 1'b1;
        pulse(1'b0);
        check({31'h0, frame_running}, 32'h0);
        check(base, 32'h0000_0040);
        rd_chk(`AFBIC_OFS_BUF_BASE, 32'h0000_2000);
    endtask : t_ce_freeze

    task automatic t_unmapped_and_reset();
        wr(8'h40, 32'hffff_ffff, 4'hf);
        rd_chk(8'h40, 32'h0);
        rd_chk(`AFBIC_OFS_BUF_BASE, 32'h0000_2000);
        @(posedge clk_sys);
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        rd_chk(`AFBIC_OFS_BUF_BASE, 32'h0);
        rd_chk(`AFBIC_OFS_STATUS, 32'h0);
        check(base, 32'h0);
    endtask : t_unmapped_and_reset

    initial begin
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset_vals();
        t_taps();
        t_base_frame();
        t_status();
        t_ce_freeze();
        t_unmapped_and_reset();
        complete_run();
    end
endmodule : afbic_top_tb_top

`default_nettype wire
